// ===== shared/mia_pkg.sv
// Constants, register map and state encoding for the monitor indirect access port.
// Assumes a single host register port and a monitor core on the same clock.
package mia_pkg;
  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 3;
  localparam int EVT_A_W = 7;
  localparam int EVT_B_W = 8;

  // Host register offsets, byte-wide registers at the printed offsets.
  localparam logic [2:0] OFF_MONITOR_INDEX = 3'h0;
  localparam logic [2:0] OFF_MONITOR_DATA_PORT = 3'h1;
  localparam logic [2:0] OFF_MONITOR_STATUS_COMMAND = 3'h2;
  localparam logic [2:0] OFF_EVENT_REGISTER_A = 3'h3;
  localparam logic [2:0] OFF_EVENT_REGISTER_B = 3'h4;

  // Field positions in the status and command register.
  localparam int BUSY_BIT = 0;
  localparam int READ_KICK_BIT = 1;

  // Field positions in event register A.
  localparam int TWO_V5_EVENT_BIT = 0;
  localparam int CORE_VOLT_EVENT_BIT = 1;
  localparam int THREE_V3_EVENT_BIT = 2;
  localparam int FIVE_VOLT_EVENT_BIT = 3;
  localparam int TEMP_ZONE_ONE_EVENT_BIT = 4;
  localparam int TEMP_ZONE_TWO_EVENT_BIT = 5;
  localparam int TEMP_ZONE_THREE_EVENT_BIT = 6;

  // Field positions in event register B.
  localparam int TWELVE_VOLT_EVENT_BIT = 0;
  localparam int PRIMARY_SENSOR_LINK_EVENT_BIT = 1;
  localparam int TACH_ONE_EVENT_BIT = 2;
  localparam int TACH_FOUR_EVENT_BIT = 5;
  localparam int REMOTE_DIODE_EVENT_BIT = 6;
  localparam int SECONDARY_SENSOR_LINK_EVENT_BIT = 7;

  // Reset values.
  localparam logic [7:0] RST_MONITOR_INDEX = 8'h00;
  localparam logic [7:0] RST_MONITOR_DATA_PORT = 8'h00;
  localparam logic [6:0] RST_EVENT_REGISTER_A = 7'h00;
  localparam logic [7:0] RST_EVENT_REGISTER_B = 8'h00;

  typedef enum logic [1:0] {
    MIA_IDLE = 2'h0,
    MIA_WAIT = 2'h1
  } mia_state_e;
endpackage

// ===== design/mia_indirect_events.sv
// Indirect access port into the monitor register file, plus two sticky event registers.
// Assumes the host register port and monitor core run on ref_clk_i, so no synchronisers.
//
// Function
// (R1) Writing the data port launches a write to the register selected by index.
// (R2) Data port writes while busy are dropped; nothing starts, stored value unchanged.
// (R3) Host must ignore data port read values while busy is set.
// (R4) Writing one to read kick starts a read at index into data port.
// (R5) Host sets read kick only while busy is clear.
// (R6) Busy reads one during an access, zero when data valid or ready.
// (R7) Event bits stay set until the host writes one to them.
// (R8) Event A bits six to four latch temperature zone three, two, one changes.
// (R9) Event A bits three to zero latch five, three-three, core, two-five volt changes.
// (R10) Event B bit zero latches twelve volt monitor changes.
// (R11) Event B bits two to five latch tach one to four changes.
// (R12) Event B bit one latches primary sensor link events.
// (R13) Event B bit seven latches secondary sensor link events.
// (R14) Event B bit six latches remote diode connection events.
// (R15) Writing one clears an event bit, writing zero leaves it.
// (R16) Host waits for busy clear, then writes index at offset zero.
// (R17) Interrupt request rises when an enabled event bit is set.
// (R18) Reserved status and event bits read zero and ignore writes.
`timescale 1ns/1ps
module mia_indirect_events #(
  parameter int DATA_W = mia_pkg::DATA_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [mia_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic mon_req_o,
  output logic mon_we_o,
  output logic [7:0] mon_addr_o,
  output logic [7:0] mon_wdata_o,
  input wire logic mon_ack_i,
  input wire logic [7:0] mon_rdata_i,
  input wire logic [mia_pkg::EVT_A_W-1:0] evt_a_i,
  input wire logic [mia_pkg::EVT_B_W-1:0] evt_b_i,
  input wire logic [mia_pkg::EVT_A_W-1:0] irq_en_a_i,
  input wire logic [mia_pkg::EVT_B_W-1:0] irq_en_b_i,
  output logic irq_o
);

  // The register layout is byte wide throughout; other widths have no meaning here.
  if (DATA_W != 8) begin : g_bad_width
    $error("mia_indirect_events supports DATA_W of 8 only");
  end

  mia_pkg::mia_state_e state_reg, state_next;
  logic [7:0] index_reg, index_next;
  logic [7:0] data_reg, data_next;
  logic req_reg, req_next;
  logic we_reg, we_next;
  logic [7:0] maddr_reg, maddr_next;
  logic [7:0] mwdata_reg, mwdata_next;
  logic [mia_pkg::EVT_A_W-1:0] evta_reg, evta_next, clr_a;
  logic [mia_pkg::EVT_B_W-1:0] evtb_reg, evtb_next, clr_b;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic busy;

  // Decodes a host write to one offset; used for every writable register.
  function automatic logic wr_hit(input logic wr, input logic [2:0] addr, input logic [2:0] off);
    wr_hit = wr && (addr == off);
  endfunction

  assign busy = (state_reg != mia_pkg::MIA_IDLE);

  // Index register; the host is trusted not to move it while busy, and the
  // address is copied at launch so a late change cannot disturb a running access.
  always_comb begin
    index_next = index_reg;
    if (wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_MONITOR_INDEX)) begin
      index_next = reg_wdata_i;
    end
  end

  // Access sequencer: launches writes and reads and waits for the core's ack.
  always_comb begin
    state_next = state_reg;
    data_next = data_reg;
    req_next = req_reg;
    we_next = we_reg;
    maddr_next = maddr_reg;
    mwdata_next = mwdata_reg;
    case (state_reg)
      mia_pkg::MIA_IDLE: begin
        if (wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_MONITOR_DATA_PORT)) begin
          data_next = reg_wdata_i; // see (R1)
          req_next = 1'b1;
          we_next = 1'b1;
          maddr_next = index_reg;
          mwdata_next = reg_wdata_i;
          state_next = mia_pkg::MIA_WAIT; // see (R6)
        end else if (wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_MONITOR_STATUS_COMMAND) &&
                     reg_wdata_i[mia_pkg::READ_KICK_BIT]) begin
          req_next = 1'b1; // see (R4)
          we_next = 1'b0;
          maddr_next = index_reg;
          state_next = mia_pkg::MIA_WAIT;
        end
      end
      mia_pkg::MIA_WAIT: begin
        // Writes to the data port and kicks are dropped here. see (R2) (R5)
        if (mon_ack_i) begin
          req_next = 1'b0;
          we_next = 1'b0;
          if (!we_reg) begin
            data_next = mon_rdata_i; // see (R4)
          end
          state_next = mia_pkg::MIA_IDLE; // see (R6)
        end
      end
      default: begin
        state_next = mia_pkg::MIA_IDLE;
        req_next = 1'b0;
        we_next = 1'b0;
      end
    endcase
  end

  // Sticky event bits: an event in the clearing cycle wins over the clear.
  always_comb begin
    clr_a = '0;
    clr_b = '0;
    if (wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_EVENT_REGISTER_A)) begin
      clr_a = reg_wdata_i[mia_pkg::EVT_A_W-1:0]; // see (R15) (R18)
    end
    if (wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_EVENT_REGISTER_B)) begin
      clr_b = reg_wdata_i; // see (R15)
    end
    evta_next = (evta_reg & ~clr_a) | evt_a_i; // see (R7) (R8) (R9)
    evtb_next = (evtb_reg & ~clr_b) | evt_b_i; // see (R7) (R10) (R11) (R12) (R13) (R14)
  end

  // Interrupt request is a level of the enabled sticky bits, one cycle behind them.
  always_comb begin
    irq_next = (|(evta_reg & irq_en_a_i)) | (|(evtb_reg & irq_en_b_i)); // see (R17)
  end

  // Read mux, registered; unmapped offsets and idle cycles return zero.
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        mia_pkg::OFF_MONITOR_INDEX: rdata_next = index_reg;
        mia_pkg::OFF_MONITOR_DATA_PORT: rdata_next = data_reg; // see (R3)
        mia_pkg::OFF_MONITOR_STATUS_COMMAND: rdata_next = {7'h00, busy}; // see (R6) (R18)
        mia_pkg::OFF_EVENT_REGISTER_A: rdata_next = {1'b0, evta_reg}; // see (R18)
        mia_pkg::OFF_EVENT_REGISTER_B: rdata_next = evtb_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // All state registers; clock enable low freezes everything.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= mia_pkg::MIA_IDLE;
      index_reg <= mia_pkg::RST_MONITOR_INDEX;
      data_reg <= mia_pkg::RST_MONITOR_DATA_PORT;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      maddr_reg <= 8'h00;
      mwdata_reg <= 8'h00;
      evta_reg <= mia_pkg::RST_EVENT_REGISTER_A;
      evtb_reg <= mia_pkg::RST_EVENT_REGISTER_B;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      index_reg <= index_next;
      data_reg <= data_next;
      req_reg <= req_next;
      we_reg <= we_next;
      maddr_reg <= maddr_next;
      mwdata_reg <= mwdata_next;
      evta_reg <= evta_next;
      evtb_reg <= evtb_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign mon_req_o = req_reg;
  assign mon_we_o = we_reg;
  assign mon_addr_o = maddr_reg;
  assign mon_wdata_o = mwdata_reg;
  assign irq_o = irq_reg;

  // Named steps of an indirect access.
  sequence s_idle_data_write;
    ce_i && !busy && wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_MONITOR_DATA_PORT);
  endsequence

  sequence s_idle_kick;
    ce_i && !busy && !wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_MONITOR_DATA_PORT) &&
      wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_MONITOR_STATUS_COMMAND) &&
      reg_wdata_i[mia_pkg::READ_KICK_BIT];
  endsequence

  a_write_launch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R1)
    s_idle_data_write |=> mon_req_o && mon_we_o && busy &&
      mon_addr_o == $past(index_reg) && mon_wdata_o == $past(reg_wdata_i))
    else $error("data port write did not launch a write access");

  a_busy_write_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R2)
    ce_i && busy && !mon_ack_i && wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_MONITOR_DATA_PORT)
      |=> $stable(data_reg) && $stable(mon_wdata_o) && busy)
    else $error("data port write while busy was not ignored");

  a_read_launch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R4)
    s_idle_kick |=> mon_req_o && !mon_we_o && mon_addr_o == $past(index_reg))
    else $error("read kick did not start a read");

  a_read_return: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R4)
    ce_i && busy && !mon_we_o && mon_ack_i |=> !busy && data_reg == $past(mon_rdata_i))
    else $error("read data not captured into data port");

  a_busy_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R6)
    ce_i && reg_rd_i && reg_addr_i == mia_pkg::OFF_MONITOR_STATUS_COMMAND
      |=> reg_rdata_o == {7'h00, $past(busy)})
    else $error("status read does not show busy");

  a_busy_until_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R6)
    ce_i && busy && !mon_ack_i |=> busy && mon_req_o)
    else $error("busy dropped before the access completed");

  a_sticky_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R7)
    ce_i && !wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_EVENT_REGISTER_B)
      |=> (evtb_reg & $past(evtb_reg)) == $past(evtb_reg))
    else $error("event bit cleared without a host write");

  a_sticky_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R7)
    ce_i && !wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_EVENT_REGISTER_A)
      |=> (evta_reg & $past(evta_reg)) == $past(evta_reg))
    else $error("event a bit cleared without a host write");

  a_event_a_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R8) (R9)
    ce_i && evt_a_i != 7'h00 |=> (evta_reg & $past(evt_a_i)) == $past(evt_a_i))
    else $error("event register a missed an event");

  a_event_b_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R11) (R14)
    ce_i && evt_b_i != 8'h00 |=> (evtb_reg & $past(evt_b_i)) == $past(evt_b_i))
    else $error("event register b missed an event");

  a_w1c_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R15)
    ce_i && wr_hit(reg_wr_i, reg_addr_i, mia_pkg::OFF_EVENT_REGISTER_A) && evt_a_i == 7'h00
      |=> evta_reg == ($past(evta_reg) & ~$past(reg_wdata_i[6:0])))
    else $error("write one to clear misbehaved");

  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R17)
    ce_i |=> irq_o == ($past(|(evta_reg & irq_en_a_i)) || $past(|(evtb_reg & irq_en_b_i))))
    else $error("interrupt request does not follow enabled events");

  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // see (R18)
    ce_i && reg_rd_i && reg_addr_i == mia_pkg::OFF_EVENT_REGISTER_A |=> !reg_rdata_o[7])
    else $error("reserved event bit reads nonzero");

endmodule

// ===== testbench/mia_monitor_model.sv
// Behavioural model of the monitor register file behind the indirect access port.
// Assumes one request at a time, held by the design until the edge after its acknowledge.
`timescale 1ns/1ps
module mia_monitor_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] lat_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  logic [3:0] cnt_reg;
  int wcnt;

  // Wait the chosen latency, then answer once; between answers the read lines toggle.
  // The toggling means a design that samples read data off its acknowledge sees garbage.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt_reg <= 4'h0;
      rdata_o <= 8'hA5;
      wcnt <= 0;
    end else if (req_i && !ack_o && cnt_reg >= lat_i) begin
      ack_o <= 1'b1;
      cnt_reg <= 4'h0;
      if (we_i) begin
        mem[addr_i] <= wdata_i;
        wcnt <= wcnt + 1;
        rdata_o <= ~rdata_o;
      end else begin
        rdata_o <= mem[addr_i];
      end
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

// ===== testbench/mia_indirect_events_tb.sv
// Self-checking bench for the indirect access port and the sticky event registers.
// Assumes the bench plays the host and the monitor model answers the internal requests.
`timescale 1ns/1ps
module mia_indirect_events_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o, mon_addr_o, mon_wdata_o, mon_rdata_i, got;
  logic mon_req_o, mon_we_o, mon_ack_i, irq_o;
  logic [6:0] evt_a_i = 7'h00;
  logic [6:0] irq_en_a_i = 7'h00;
  logic [7:0] evt_b_i = 8'h00;
  logic [7:0] irq_en_b_i = 8'h00;
  logic [3:0] lat = 4'h6;
  int n_errors = 0;
  int checks = 0;

  // Free-running 40 MHz clock.
  always #12.5 ref_clk_i = ~ref_clk_i;

  mia_indirect_events mia_indirect_events_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .mon_req_o(mon_req_o),
    .mon_we_o(mon_we_o), .mon_addr_o(mon_addr_o), .mon_wdata_o(mon_wdata_o),
    .mon_ack_i(mon_ack_i), .mon_rdata_i(mon_rdata_i), .evt_a_i(evt_a_i), .evt_b_i(evt_b_i),
    .irq_en_a_i(irq_en_a_i), .irq_en_b_i(irq_en_b_i), .irq_o(irq_o));

  mia_monitor_model partner (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .lat_i(lat),
    .req_i(mon_req_o), .we_i(mon_we_o), .addr_i(mon_addr_o), .wdata_i(mon_wdata_o),
    .ack_o(mon_ack_i), .rdata_o(mon_rdata_i));

  task automatic wrap_up();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Host write: strobe held for one full cycle around the taking edge.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask

  // Host read: the registered answer is taken in the cycle after the strobe.
  task automatic rd_raw(input logic [2:0] a);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    got = reg_rdata_o;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rd_raw(a);
    chk(got, e);
  endtask

  // Polls busy with a bound, so a stuck access shows up as a mismatch rather than a hang.
  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      rd_raw(3'h2);
      if (got[0] === 1'b0) break;
    end
    chk(got, 8'h00);
  endtask

  // Pulses one event source, checks stickiness, write-zero, interrupt and write-one clear.
  // The disabled case enables every other bit, so a wrong enable lane shows up as an irq.
  task automatic ev(input int i, input bit en);
    logic [2:0] a;
    logic [7:0] m;
    a = (i < 7) ? 3'h3 : 3'h4;
    m = 8'h01 << ((i < 7) ? i : i - 7);
    @(negedge ref_clk_i);
    {irq_en_b_i, irq_en_a_i} = en ? 15'h7FFF : ~(15'h0001 << i);
    {evt_b_i, evt_a_i} = 15'h0001 << i;
    @(negedge ref_clk_i);
    {evt_b_i, evt_a_i} = 15'h0000;
    rd(a, m);
    wr(a, ~m);
    rd(a, m);
    chk({7'h00, irq_o}, {7'h00, en});
    wr(a, m);
    rd(a, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
  endtask

  // Main sequence: reset values, write launch, busy refusal, reads, then every event bit.
  initial begin
    repeat (16) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wait_idle();
    wr(3'h0, 8'h5A);
    rd(3'h0, 8'h5A);
    wr(3'h1, 8'hC3);
    rd(3'h2, 8'h01);
    wr(3'h1, 8'h11);
    wait_idle();
    chk(partner.mem[8'h5A], 8'hC3);
    chk(partner.wcnt[7:0], 8'h01);
    rd(3'h1, 8'hC3);
    lat = 4'h0;
    wr(3'h0, 8'h33);
    wr(3'h1, 8'h77);
    wait_idle();
    wr(3'h0, 8'h5A);
    wr(3'h2, 8'h02);
    wait_idle();
    rd(3'h1, 8'hC3);
    wr(3'h0, 8'h33);
    wr(3'h2, 8'hFD);
    rd(3'h2, 8'h00);
    rd(3'h1, 8'hC3);
    lat = 4'h6;
    wr(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    wait_idle();
    rd(3'h1, 8'h77);
    for (int i = 0; i < 15; i++) ev(i, i != 3);
    // An event in the very cycle of its own clear must survive; the set wins.
    @(negedge ref_clk_i);
    evt_b_i = 8'h04;
    reg_addr_i = 3'h4;
    reg_wdata_i = 8'h04;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    evt_b_i = 8'h00;
    reg_wr_i = 1'b0;
    rd(3'h4, 8'h04);
    wr(3'h4, 8'h04);
    rd(3'h4, 8'h00);
    wrap_up();
  end

  // Watchdog sized well beyond the few hundred cycles the sequence needs.
  initial begin
    #500000;
    n_errors++;
    wrap_up();
  end
endmodule
